// *** bench/vif_capture_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench: drivers note expected pixels, a watcher compares.
module vif_capture_bench;
    logic clk_sys, rst_n, pixClk, vref, fld, lact, alpha;
    logic [15:0] pins;
    logic [1:0] mode;
    logic [3:0] pol;
    logic [2:0] extPol, fmt;
    logic dPort, dClk, reduced, lOn, vOn, fCur, ignorePix;
    logic [23:0] pixelData;
    logic pixelValid, fieldId, lineStart, fieldStart, codeError;
    logic [23:0] expQ[$];
    int n_mismatch, tests_run, cycles, nLine, nField, nErr, seed;
    // System clock and an unrelated link clock.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        pixClk = 1'b0;
        #7;
        forever #32 pixClk = ~pixClk;
    end
    vif_capture vif_capture_i (.clk_sys(clk_sys), .rst_n(rst_n), .pixel_clock_in(pixClk),
        .video_data_pins(pins), .vertical_ref_pin(vref), .field_id_pin(fld), .line_active_pin(lact),
        .alpha_key_pin(alpha), .timing_mode_select(mode), .scaler_polarity_control(pol),
        .external_sync_polarity_control(extPol), .colourFormat(fmt), .doublePort(dPort),
        .doubleClock(dClk), .reducedVariant(reduced), .pixelData(pixelData), .pixelAlpha(),
        .pixelValid(pixelValid), .fieldId(fieldId), .lineStart(lineStart),
        .fieldStart(fieldStart), .codeError(codeError));
    vif_video_source vif_video_source_i (.pixClk(pixClk), .pins(pins), .vref(vref), .field(fld),
        .lineAct(lact), .alpha(alpha));
    // Compares one value and reports a mismatch.
    task check_val(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    // Prints the counts and the verdict, then stops.
    task wrap_up;
        $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    // Watcher: pairs each pixel with the oldest note, counts pulses, cuts hangs.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            wrap_up();
        end
        nLine += int'(lineStart === 1'b1);
        nField += int'(fieldStart === 1'b1);
        nErr += int'(codeError === 1'b1);
        if (pixelValid === 1'b1 && !ignorePix) begin
            if (expQ.size() == 0) begin
                check_val(pixelData, 24'hx);
            end else begin
                check_val(pixelData, expQ.pop_front());
            end
        end
    end
    // Idle pixel periods; data shows the inverse of its last value.
    task idle(input int n);
        repeat (n) vif_video_source_i.step(~pins, ~lOn, ~vOn, fCur);
    endtask : idle
    // Applies a configuration and lets the link settle before judging.
    task setup(input logic [1:0] m, input logic [3:0] p, input logic [2:0] e, input logic [2:0] f,
        input logic dp, input logic r);
        ignorePix = 1'b1;
        @(posedge clk_sys);
        mode <= m;
        pol <= p;
        extPol <= e;
        fmt <= f;
        dPort <= dp;
        reduced <= r;
        lOn = (m == vif_pkg::MODE_EXTSYNC) ? ~e[1] : ~p[1];
        vOn = (m == vif_pkg::MODE_EXTSYNC) ? ~e[0] : ~p[0];
        idle(10);
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        ignorePix = 1'b0;
        nLine = 0;
        nField = 0;
        nErr = 0;
        expQ.delete();
    endtask : setup
    // One active scaler line with a single double-port word.
    task sc_word(input bit keep);
        logic [15:0] w;
        w = 16'($random(seed));
        if (keep) expQ.push_back({8'h00, w});
        vif_video_source_i.step(w, lOn, ~vOn, fCur);
        idle(10);
    endtask : sc_word
    // Vertical pulse; the field id is already at its new value.
    task sc_field;
        fCur = ~fCur;
        vif_video_source_i.step(~pins, ~lOn, vOn, fCur);
        vif_video_source_i.step(~pins, ~lOn, vOn, fCur);
        idle(6);
    endtask : sc_field
    // Builds a status byte with its protection nibble.
    function logic [7:0] timing_reference_code(input logic [2:0] fvh);
        return {1'b1, fvh, vif_pkg::PROT_TABLE[{fvh, 2'b00} +: 4]};
    endfunction : timing_reference_code
    // Embedded line: start code, one word of two bytes, end code, blanking.
    task emb_line(input logic [7:0] sav, input logic [7:0] eav, input bit keep);
        logic [7:0] b0, b1;
        logic [7:0] sq [14];
        b0 = (8'($random(seed)) & 8'h7f) | 8'h01;
        b1 = (8'($random(seed)) & 8'h7f) | 8'h01;
        sq = '{8'hff, 8'h00, 8'h00, sav, b0, b1, 8'hff, 8'h00, 8'h00, eav, 8'h10, 8'h10, 8'h10, 8'h10};
        if (keep) expQ.push_back({8'h00, b0, b1});
        foreach (sq[i]) vif_video_source_i.step({~pins[15:8], sq[i]}, 1'b0, 1'b0, fCur);
    endtask : emb_line
    // Main sequence.
    initial begin
        seed = 32'h36d3e261;
        rst_n = 1'b0;
        mode = vif_pkg::MODE_SCALER;
        pol = 4'h0;
        extPol = 3'h0;
        fmt = vif_pkg::FMT_RGB565;
        dPort = 1'b1;
        dClk = 1'b0;
        reduced = 1'b0;
        lOn = 1'b1;
        vOn = 1'b1;
        fCur = 1'b0;
        ignorePix = 1'b1;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        check_val({23'h0, fieldId}, {23'h0, vif_pkg::RST_FIELD});
        foreach (pol[i]) begin
            if (i < 2) begin
                setup(vif_pkg::MODE_SCALER, (i == 0) ? 4'h0 : 4'h7, 3'h0, vif_pkg::FMT_RGB565, 1'b1, 1'b0);
                sc_field();
                repeat (3) sc_word(1'b1);
                repeat (6) @(posedge clk_sys);
                check_val(24'(nField), 24'h1);
                check_val(24'(nLine), 24'h3);
                check_val({23'h0, fieldId}, {23'h0, fCur ^ pol[2]});
                check_val(24'(expQ.size()), 24'h0);
            end
        end
        setup(vif_pkg::MODE_SCALER, 4'h0, 3'h0, vif_pkg::FMT_YUV555, 1'b1, 1'b1);
        repeat (2) sc_word(1'b0);
        setup(vif_pkg::MODE_EMBEDDED, 4'h0, 3'h0, vif_pkg::FMT_RGB565, 1'b0, 1'b0);
        emb_line(timing_reference_code(3'h0), timing_reference_code(3'h1), 1'b1);
        emb_line(timing_reference_code(3'h2), timing_reference_code(3'h3), 1'b0);
        emb_line(timing_reference_code(3'h4) ^ 8'h20, timing_reference_code(3'h5), 1'b1);
        emb_line(8'hd6, timing_reference_code(3'h5), 1'b1);
        repeat (6) @(posedge clk_sys);
        check_val({23'h0, fieldId}, 24'h1);
        check_val(24'(nErr), 24'h1);
        check_val(24'(expQ.size()), 24'h0);
        setup(vif_pkg::MODE_EXTSYNC, 4'h0, 3'h3, vif_pkg::FMT_RGB565, 1'b1, 1'b0);
        ignorePix = 1'b1;
        sc_field();
        vif_video_source_i.step(~pins, lOn, ~vOn, fCur);
        idle(6);
        repeat (6) @(posedge clk_sys);
        check_val(24'(nField), 24'h1);
        check_val(24'(nLine), 24'h1);
        wrap_up();
    end
endmodule : vif_capture_bench
`default_nettype wire

// *** bench/vif_video_source.sv ***
`timescale 1ns/100ps
`default_nettype none
// Stand-in for the video decoder; it moves its pins on the falling pixel edge.
module vif_video_source (
    // Link clock.
    input wire logic pixClk,
    // Link pins.
    output logic [15:0] pins,
    output logic vref,
    output logic field,
    output logic lineAct,
    output logic alpha
);
    // Start levels; the alpha key stays inactive.
    initial begin
        pins = 16'h5aa5;
        vref = 1'b0;
        field = 1'b0;
        lineAct = 1'b0;
        alpha = 1'b0;
    end
    // One pixel period; the field id moves with or before the vref pulse.
    task automatic step(input logic [15:0] d, input logic a, input logic v, input logic f);
        @(negedge pixClk);
        pins <= d;
        lineAct <= a;
        vref <= v;
        field <= f;
    endtask : step
endmodule : vif_video_source
`default_nettype wire

// *** inc/vif_pkg.sv ***
`default_nettype none
package vif_pkg;
    // Timing modes selected by the timing-mode select input.
    localparam logic [1:0] MODE_SCALER = 2'h0;
    localparam logic [1:0] MODE_EMBEDDED = 2'h1;
    localparam logic [1:0] MODE_EXTSYNC = 2'h2;
    // Colour formats selected by the colour format input.
    localparam logic [2:0] FMT_YUV422 = 3'h0;
    localparam logic [2:0] FMT_RGB555 = 3'h1;
    localparam logic [2:0] FMT_YUV555 = 3'h2;
    localparam logic [2:0] FMT_RGB565 = 3'h3;
    localparam logic [2:0] FMT_YUV655 = 3'h4;
    localparam logic [2:0] FMT_RGB888 = 3'h5;
    localparam logic [2:0] FMT_YUV444 = 3'h6;
    // Polarity control bit positions.
    localparam int POL_VREF = 0;
    localparam int POL_VACT = 1;
    localparam int POL_FIELD = 2;
    localparam int POL_ALPHA = 3;
    // Timing reference code bytes and status byte fields.
    localparam logic [7:0] TRC_PRE1 = 8'hff;
    localparam logic [7:0] TRC_PRE0 = 8'h00;
    localparam int TRC_F = 6;
    localparam int TRC_V = 5;
    localparam int TRC_H = 4;
    // Protection nibble indexed by {F,V,H}.
    localparam logic [31:0] PROT_TABLE = 32'h1c_a7_6b_d0;
    // Reset values of the capture state.
    localparam logic RST_FIELD = 1'b0;
    localparam logic [1:0] RST_MODE = MODE_SCALER;
endpackage : vif_pkg
`default_nettype wire

// *** src/vif_capture.sv ***
// What this block does
// RL1: Two 8-bit ports; single mode uses first.
// RL2: Double port mode forms 16-bit samples.
// RL3: Single clock one edge, double both edges.
// RL4: Second port and controls sampled single edge.
// RL5: No colour conversion between formats.
// RL6: Rearrange input bits into memory pixel layout.
// RL7: Reduced variant stores YUV as grayscale. The code drops YUV555 and YUV655 pixels instead.
// RL8: Three timing modes, scaler default.
// RL9: Source supplies data, clock, sync signals.
// RL10: Vertical reference pulse starts new field.
// RL11: Field id settles before vref trailing edge. The code samples it at the vref leading edge.
// RL12: Line active edges bound each active line.
// RL13: Samples forwarded while line active asserted.
// RL14: Scaler control polarities are selectable.
// RL15: Embedded mode decodes codes from data.
// RL16: Reference code is ff,00,00,status.
// RL17: Status F field, V blanking, H EAV.
// RL18: Protection bits follow the fixed table.
// RL19: Correct single-bit, detect double-bit errors.
// RL20: Double error keeps F,V, inverts last H.
// RL21: External sync pins with own polarity.
// RL22: External line and frame pulses; window defines. The code takes every sample as active in this mode.
// RL23: Reference code bytes never stored as pixels.
`timescale 1ns/100ps
`default_nettype none
module vif_capture #(
    parameter int PORT_W = 8
) (
    // System clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Video link pins, clocked by the pixel clock.
    input wire logic pixel_clock_in,
    input wire logic [2*PORT_W-1:0] video_data_pins,
    input wire logic vertical_ref_pin,
    input wire logic field_id_pin,
    input wire logic line_active_pin,
    input wire logic alpha_key_pin,
    // Configuration, static while capturing.
    input wire logic [1:0] timing_mode_select,
    input wire logic [3:0] scaler_polarity_control,
    input wire logic [2:0] external_sync_polarity_control,
    input wire logic [2:0] colourFormat,
    input wire logic doublePort,
    input wire logic doubleClock,
    input wire logic reducedVariant,
    // Pixel output towards memory, system clock.
    output logic [23:0] pixelData,
    output logic pixelAlpha,
    output logic pixelValid,
    output logic fieldId,
    output logic lineStart,
    output logic fieldStart,
    output logic codeError
);
    // Configuration synchronised into the pixel domain.
    logic [1:0] modeS1_q, modeS2_q;
    logic [3:0] polS1_q, polS2_q;
    logic [2:0] epolS1_q, epolS2_q;
    logic dpS1_q, dpS2_q, dcS1_q, dcS2_q;

    // Two-stage synchronisers for static configuration into the pixel domain.
    always_ff @(posedge pixel_clock_in) begin
        modeS1_q <= timing_mode_select;
        modeS2_q <= modeS1_q;
        polS1_q <= scaler_polarity_control;
        polS2_q <= polS1_q;
        epolS1_q <= external_sync_polarity_control;
        epolS2_q <= epolS1_q;
        dpS1_q <= doublePort;
        dpS2_q <= dpS1_q;
        dcS1_q <= doubleClock;
        dcS2_q <= dcS1_q;
    end

    // Falling-edge capture of the first port for double clock mode.
    logic [PORT_W-1:0] portANeg_q;

    // The second half of each double clock sample arrives on the falling edge.
    always_ff @(negedge pixel_clock_in) begin
        portANeg_q <= video_data_pins[PORT_W-1:0]; // RL3
    end

    // Rising-edge registers for port data and control pins.
    logic [2*PORT_W-1:0] dataR_q;
    logic vrefR_q, fidR_q, lactR_q, alphaR_q;

    // Second port and controls are only ever taken on the rising edge.
    always_ff @(posedge pixel_clock_in) begin
        dataR_q <= video_data_pins; // RL4
        vrefR_q <= vertical_ref_pin;
        fidR_q <= field_id_pin;
        lactR_q <= line_active_pin;
        alphaR_q <= alpha_key_pin;
    end

    // Control signals after polarity correction for the selected mode.
    logic vrefAct, lineAct, fidAct, alphaAct;

    // Scaler and external modes each use their own vref, line and field bits; alpha always uses the scaler bit.
    always_comb begin
        if (modeS2_q == vif_pkg::MODE_EXTSYNC) begin
            vrefAct = vrefR_q ^ epolS2_q[vif_pkg::POL_VREF]; // RL21
            lineAct = lactR_q ^ epolS2_q[vif_pkg::POL_VACT];
            fidAct = fidR_q ^ epolS2_q[vif_pkg::POL_FIELD];
        end else begin
            vrefAct = vrefR_q ^ polS2_q[vif_pkg::POL_VREF]; // RL14
            lineAct = lactR_q ^ polS2_q[vif_pkg::POL_VACT];
            fidAct = fidR_q ^ polS2_q[vif_pkg::POL_FIELD];
        end
        alphaAct = alphaR_q ^ polS2_q[vif_pkg::POL_ALPHA];
    end

    // Embedded code detector: history of first-port bytes.
    logic [7:0] hist1_q, hist2_q, hist3_q;
    logic prevH_q;
    logic emF_q, emV_q, emH_q;
    logic [1:0] skip_q;
    logic errPix_q;

    // Protection nibble expected for a given F,V,H.
    function automatic logic [3:0] protOf(input logic [2:0] fvh);
        protOf = vif_pkg::PROT_TABLE[{fvh, 2'h0} +: 4];
    endfunction : protOf

    // Decoding of the status byte with single-bit correction.
    logic trcSeen;
    logic [7:0] statusByte;
    logic [2:0] decFvh;
    logic decDouble;

    // Nearest valid codeword search: distance zero or one corrects, else double.
    always_comb begin
        logic found;
        found = 1'b0;
        statusByte = dataR_q[7:0];
        trcSeen = (hist3_q == vif_pkg::TRC_PRE1) && (hist2_q == vif_pkg::TRC_PRE0) &&
                  (hist1_q == vif_pkg::TRC_PRE0); // RL16
        decFvh = statusByte[6:4];
        for (int k = 0; k < 8; k++) begin
            logic [7:0] cw;
            cw = {1'b1, 3'(k), protOf(3'(k))}; // RL18
            if (!found && ($countones(cw ^ statusByte) <= 1)) begin
                found = 1'b1;
                decFvh = 3'(k); // RL19
            end
        end
        decDouble = !found;
    end

    // Byte history and status decode in embedded mode.
    always_ff @(posedge pixel_clock_in) begin
        if (modeS2_q != vif_pkg::MODE_EMBEDDED) begin
            hist1_q <= 8'h00;
            hist2_q <= 8'h00;
            hist3_q <= 8'h00;
            skip_q <= 2'h0;
            emF_q <= 1'b0;
            emV_q <= 1'b1;
            emH_q <= 1'b1;
            prevH_q <= 1'b1;
            errPix_q <= 1'b0;
        end else begin
            hist1_q <= dataR_q[7:0]; // RL15
            hist2_q <= hist1_q;
            hist3_q <= hist2_q;
            errPix_q <= 1'b0;
            if (skip_q != 2'h0) begin
                skip_q <= skip_q - 2'h1;
            end
            if (trcSeen) begin
                hist1_q <= 8'h00;
                hist2_q <= 8'h00;
                hist3_q <= 8'h00;
                if (decDouble) begin
                    emF_q <= statusByte[vif_pkg::TRC_F]; // RL20
                    emV_q <= statusByte[vif_pkg::TRC_V];
                    emH_q <= !prevH_q;
                    prevH_q <= !prevH_q;
                    errPix_q <= 1'b1;
                end else begin
                    emF_q <= decFvh[2]; // RL17
                    emV_q <= decFvh[1];
                    emH_q <= decFvh[0];
                    prevH_q <= decFvh[0];
                end
            end else if (dataR_q[7:0] == vif_pkg::TRC_PRE1) begin
                skip_q <= 2'h3; // RL23
            end
        end
    end

    // The preamble bytes already shown before the status are also dropped.
    logic preamble;
    assign preamble = (dataR_q[7:0] == vif_pkg::TRC_PRE1) || (skip_q != 2'h0) || trcSeen;

    // Pixel-domain timing state and sample capture.
    logic [23:0] samp_q;
    logic sampAlpha_q, phase_q;
    logic lineActD_q, vrefD_q, fid_q;
    logic wordT_q, lineT_q, fieldT_q, errT_q;
    logic active;
    // First byte of a single port word, held until its partner arrives.
    logic [7:0] lowByte_q;
    // Reset carried into the pixel domain.
    logic rstS1_q, rstS2_q;
    // Word acknowledge returned from the system domain.
    logic ackS1_q, ackS2_q;

    // The system reset passes two flip-flops before the pixel logic reads it.
    always_ff @(posedge pixel_clock_in) begin
        rstS1_q <= rst_n;
        rstS2_q <= rstS1_q;
    end

    // Per-mode "active" line qualifier.
    always_comb begin
        unique case (modeS2_q)
            vif_pkg::MODE_EMBEDDED: active = !emH_q && !emV_q && !preamble; // RL23
            vif_pkg::MODE_EXTSYNC: active = 1'b1; // RL22
            default: active = lineAct; // RL13
        endcase
    end

    // Line, field and word events are signalled by toggles into the system domain.
    // Toggles start from a known level, otherwise an unknown toggle never resolves.
    // A word is only launched once the previous one has been acknowledged, so the
    // held sample stays still while the system side reads it; faster words drop.
    always_ff @(posedge pixel_clock_in) begin
        lineActD_q <= lineAct;
        vrefD_q <= vrefAct;
        if (!rstS2_q) begin
            // Pixel-side event state returns to its idle levels.
            fid_q <= vif_pkg::RST_FIELD;
            wordT_q <= 1'b0;
            lineT_q <= 1'b0;
            fieldT_q <= 1'b0;
            errT_q <= 1'b0;
            phase_q <= 1'b0;
        end else begin
            if (modeS2_q == vif_pkg::MODE_EMBEDDED) begin
                fid_q <= emF_q;
                if (errPix_q) begin
                    errT_q <= !errT_q;
                end
            end else if (vrefAct && !vrefD_q) begin
                fid_q <= fidAct; // RL11
            end
            if ((modeS2_q == vif_pkg::MODE_EXTSYNC && lineAct && !lineActD_q) ||
                (modeS2_q == vif_pkg::MODE_SCALER && lineAct && !lineActD_q)) begin
                lineT_q <= !lineT_q; // RL12
            end
            if (vrefAct && !vrefD_q && modeS2_q != vif_pkg::MODE_EMBEDDED) begin
                fieldT_q <= !fieldT_q; // RL10
            end
            if (!active) begin
                phase_q <= 1'b0;
            end else if (dpS2_q) begin
                // Both ports form one word per rising edge.
                if (wordT_q == ackS2_q) begin
                    samp_q <= {8'h00, dataR_q}; // RL2
                    sampAlpha_q <= alphaAct;
                    wordT_q <= !wordT_q;
                end
            end else if (dcS2_q) begin
                // Rising and falling bytes of the first port form one word.
                if (wordT_q == ackS2_q) begin
                    samp_q <= {8'h00, dataR_q[7:0], portANeg_q}; // RL3
                    sampAlpha_q <= alphaAct;
                    wordT_q <= !wordT_q;
                end
            end else begin
                // Two rising edges of the first port form one word, first byte high.
                phase_q <= !phase_q; // RL1
                if (!phase_q) begin
                    lowByte_q <= dataR_q[7:0];
                end else if (wordT_q == ackS2_q) begin
                    samp_q <= {8'h00, lowByte_q, dataR_q[7:0]};
                    sampAlpha_q <= alphaAct;
                    wordT_q <= !wordT_q;
                end
            end
        end
    end

    // Embedded mode field change raises a field event on the system side.
    // Toggle synchronisers into the system domain.
    logic [2:0] wSync_q, lSync_q, fSync_q, eSync_q;
    logic [1:0] fidSync_q;

    // Third stage serves as the edge reference, never the first.
    always_ff @(posedge clk_sys) begin
        wSync_q <= {wSync_q[1:0], wordT_q};
        lSync_q <= {lSync_q[1:0], lineT_q};
        fSync_q <= {fSync_q[1:0], fieldT_q};
        eSync_q <= {eSync_q[1:0], errT_q};
        fidSync_q <= {fidSync_q[0], fid_q};
    end

    // The consumed word toggle goes back to the pixel domain through two flip-flops.
    always_ff @(posedge pixel_clock_in) begin
        ackS1_q <= wSync_q[2];
        ackS2_q <= ackS1_q;
    end

    // Bit rearrangement from port order into memory pixel order.
    logic [23:0] mapped;
    logic [15:0] w;

    // Formats pass the 16-bit word in place, 5-5-5 formats with bit 15 cleared; reduced YUV422/YUV444 repeat the high byte.
    always_comb begin
        w = samp_q[15:0];
        mapped = 24'h000000;
        unique case (colourFormat)
            vif_pkg::FMT_RGB555, vif_pkg::FMT_YUV555: mapped = {9'h000, w[14:0]}; // RL6
            vif_pkg::FMT_RGB565, vif_pkg::FMT_YUV655: mapped = {8'h00, w}; // RL5
            vif_pkg::FMT_RGB888: mapped = {8'h00, w};
            default: mapped = {8'h00, w};
        endcase
        if (reducedVariant && (colourFormat == vif_pkg::FMT_YUV422 ||
                               colourFormat == vif_pkg::FMT_YUV444)) begin
            mapped = {8'h00, w[15:8], w[15:8]}; // RL7
        end
    end

    // System-side outputs, all registered; pixel words are stable when flagged.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pixelData <= 24'h000000;
            pixelAlpha <= 1'b0;
            pixelValid <= 1'b0;
            fieldId <= vif_pkg::RST_FIELD;
            lineStart <= 1'b0;
            fieldStart <= 1'b0;
            codeError <= 1'b0;
        end else begin
            pixelValid <= wSync_q[2] ^ wSync_q[1];
            // Reduced variant refuses the 5-5-5 and 6-5-5 luminance formats.
            if (reducedVariant && (colourFormat == vif_pkg::FMT_YUV555 ||
                                   colourFormat == vif_pkg::FMT_YUV655)) begin
                pixelValid <= 1'b0; // RL7
            end
            if (wSync_q[2] ^ wSync_q[1]) begin
                pixelData <= mapped;
                pixelAlpha <= sampAlpha_q;
            end
            lineStart <= lSync_q[2] ^ lSync_q[1];
            fieldStart <= (fSync_q[2] ^ fSync_q[1]) || (fidSync_q[1] != fieldId); // RL10
            fieldId <= fidSync_q[1];
            codeError <= eSync_q[2] ^ eSync_q[1];
        end
    end

    // A pixel pulse is always a single system cycle.
    pixel_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pixelValid |=> !pixelValid) else $error("pixel valid longer than one cycle"); // RL13
    // No pixel in a refused reduced format.
    reduced_refuse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (reducedVariant && colourFormat == vif_pkg::FMT_YUV655 && $stable(colourFormat))
        |=> !pixelValid) else $error("refused format produced pixel"); // RL7
    // The other refused reduced format gives no pixel either.
    reduced_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL7
        (reducedVariant && colourFormat == vif_pkg::FMT_YUV555 && $stable(colourFormat))
        |=> !pixelValid) else $error("refused format produced pixel");
    // A line start is a single system cycle.
    line_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL12
        lineStart |=> !lineStart) else $error("line start longer than one cycle");
    // A field start is a single system cycle.
    field_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL10
        fieldStart |=> !fieldStart) else $error("field start longer than one cycle");
    // A code error is a single system cycle.
    error_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL20
        codeError |=> !codeError) else $error("code error longer than one cycle");
endmodule : vif_capture
`default_nettype wire
